// [rtl/ebs_pkg.sv]
// shared constants and types for the external bus strobe interface
package ebs_pkg;

	localparam int          EBS_ADDR_W    = 24;             // internal address width
	localparam int          EBS_DATA_W    = 16;             // external data bus width
	localparam int          EBS_MA_W      = 13;             // dram multiplexed address lines
	localparam int          EBS_HIGH_W    = 8;              // high-order address byte width
	localparam int          EBS_HIGH_LSB  = 16;             // first bit of the high-order byte
	localparam int          EBS_ROW_LSB   = 9;              // row address starts at this address bit
	localparam int          EBS_COL_LSB   = 1;              // column address starts at this address bit
	localparam int          EBS_COL_W     = 9;              // column address width
	localparam logic [3:0]  EBS_DIV8_HALF = 4'h3;           // last count of a divide-by-8 half period
	localparam logic [3:0]  EBS_DIV32_HALF = 4'hf;          // last count of a divide-by-32 half period
	localparam logic [1:0]  EBS_CLK_DIV8  = 2'h0;           // clock output: main oscillator / 8
	localparam logic [1:0]  EBS_CLK_DIV32 = 2'h1;           // clock output: main oscillator / 32
	localparam logic [1:0]  EBS_CLK_SUB   = 2'h2;           // clock output: sub oscillator rate
	localparam logic        EBS_STYLE_SPLIT  = 1'b0;        // low/high byte write strobes
	localparam logic        EBS_STYLE_SINGLE = 1'b1;        // one write strobe plus high byte enable

	// bus sequencer states
	typedef enum logic [2:0] {
		EBS_IDLE,
		EBS_ADDR,
		EBS_STRB,
		EBS_ROW,
		EBS_COL,
		EBS_HOLD
	} ebs_state_t;

	// one access request from the core
	typedef struct packed {
		logic [EBS_ADDR_W-1:0] addr;    // byte address
		logic [EBS_DATA_W-1:0] wdata;   // write data, bytes in their lanes
		logic                  write;   // 1 write, 0 read
		logic                  word;    // 16-bit access from an even address
		logic                  dram;    // access falls in the dram region
		logic [1:0]            space;   // which chip select to assert
	} ebs_req_t;

	// strobe pins, all low active except the latch strobe
	typedef struct packed {
		logic rd_n;
		logic wrl_n;      // low byte write, or the single write strobe
		logic wrh_n;      // high byte write, or the high byte enable
		logic ale;
		logic ras_n;
		logic cas_even_n;
		logic cas_odd_n;
		logic dw_n;
	} ebs_strb_t;

	localparam ebs_strb_t EBS_STRB_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

	// whole state of the bus sequencer
	typedef struct packed {
		ebs_state_t            state;
		ebs_req_t              req;
		ebs_strb_t             strb;
		logic [3:0]            cs_n;
		logic [EBS_DATA_W-1:0] ad_o;
		logic                  ad_oe;
		logic [EBS_MA_W-1:0]   ma;
		logic [EBS_DATA_W-1:0] rdata;
		logic                  done;
		logic                  grant_n;
		logic                  bclk;
	} ebs_st_t;

	// state of the clock output divider
	typedef struct packed {
		logic [3:0] cnt;
		logic       div_out;
		logic       sub_q;
	} ebs_div_t;

endpackage

// [rtl/ebs_clkout.sv]
// clock output pin: main clock divided by 8 or 32, or the sub oscillator rate
`timescale 1ns/1ps
module ebs_clkout
	import ebs_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic [1:0] sel,
	input  wire logic       sub_in,
	output logic            clk_o
);

	ebs_div_t q;   // registered state
	ebs_div_t d;   // next state

	// divider counts half periods and toggles; sub clock is retimed once
	always_comb begin
		logic [3:0] last;
		last = (sel == EBS_CLK_DIV32) ? EBS_DIV32_HALF : EBS_DIV8_HALF;
		d = q;
		d.sub_q = sub_in;
		if (q.cnt >= last) begin
			// half period done
			d.cnt     = 4'h0;
			d.div_out = ~q.div_out;
		end else begin
			d.cnt = q.cnt + 4'h1;
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	// pick the source for the pin
	assign clk_o = (sel == EBS_CLK_SUB) ? q.sub_q : q.div_out;

endmodule // ebs_clkout

// [rtl/ebs_bus.sv]
// external bus sequencer: address, chip selects, strobes, dram timing, hold and wait
`timescale 1ns/1ps
module ebs_bus
	import ebs_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	input  wire logic                  strobe_style,
	input  wire logic                  bus_mux,
	input  wire logic [1:0]            clk_out_sel,
	input  wire logic                  sub_oscillator_input,
	input  wire logic                  req_valid,
	input  wire ebs_req_t              req,
	output logic                       req_ready,
	output logic                       rsp_done,
	output logic [EBS_DATA_W-1:0]      rsp_rdata,
	input  wire logic                  hold_req_n,
	output logic                       bus_release_grant_n,
	input  wire logic                  rdy,
	output logic [EBS_DATA_W-1:0]      addr_low,
	output logic [EBS_HIGH_W-2:0]      addr_high,
	output logic                       inverted_top_address,
	output logic [3:0]                 space_select_lines_n,
	output logic [EBS_MA_W-1:0]        dram_mux_address,
	input  wire logic [EBS_DATA_W-1:0] ad_i,
	output logic [EBS_DATA_W-1:0]      ad_o,
	output logic                       ad_oe,
	output logic                       rd_n,
	output logic                       write_strobe_low_byte_n,
	output logic                       write_strobe_high_byte_n,
	output logic                       ale,
	output logic                       ras_n,
	output logic                       column_strobe_even_n,
	output logic                       column_strobe_odd_n,
	output logic                       dram_write_select_n,
	output logic                       bclk,
	output logic                       clock_output_pin
);

	ebs_st_t q;   // registered state
	ebs_st_t d;   // next state

	// read and write strobes for a normal access in the chosen style
	function automatic ebs_strb_t cpu_strobes(ebs_req_t r, logic style);
		ebs_strb_t s;
		logic      odd_lane;
		logic      even_lane;
		s         = EBS_STRB_IDLE;
		odd_lane  = r.word | r.addr[0];
		even_lane = r.word | ~r.addr[0];
		s.rd_n    = r.write;
		if (style == EBS_STYLE_SPLIT) begin
			s.wrl_n = ~(r.write & even_lane);
			s.wrh_n = ~(r.write & odd_lane);
		end else begin
			s.wrl_n = ~r.write;
			s.wrh_n = ~odd_lane;
		end
		return s;
	endfunction

	// one-hot low chip select from the space number
	function automatic logic [3:0] space_decode(logic [1:0] sp);
		logic [3:0] v;
		v     = 4'hf;
		v[sp] = 1'b0;
		return v;
	endfunction

	// row and column halves of a dram address
	function automatic logic [EBS_MA_W-1:0] dram_row(logic [EBS_ADDR_W-1:0] a);
		return a[EBS_ROW_LSB +: EBS_MA_W];
	endfunction

	function automatic logic [EBS_MA_W-1:0] dram_col(logic [EBS_ADDR_W-1:0] a);
		return {{(EBS_MA_W-EBS_COL_W){1'b0}}, a[EBS_COL_LSB +: EBS_COL_W]};
	endfunction

	// next-state logic of the sequencer
	always_comb begin
		d      = q;
		d.done = 1'b0;
		d.strb = EBS_STRB_IDLE;
		d.bclk = ~q.bclk;
		case (q.state)
			EBS_IDLE: begin
				if (!hold_req_n) begin
					// hold wins over a pending request
					d.state   = EBS_HOLD;
					d.grant_n = 1'b0;
					d.ad_oe   = 1'b0;
				end else if (req_valid) begin
					d.req  = req;
					d.cs_n = space_decode(req.space);
					if (req.dram) begin
						// row address goes out with the row strobe first
						d.state      = EBS_ROW;
						d.ma         = dram_row(req.addr);
						d.strb.ras_n = 1'b0;
						d.ad_oe      = 1'b0;
					end else begin
						// address phase with the latch strobe
						d.state    = EBS_ADDR;
						d.strb.ale = 1'b1;
						d.ad_o     = req.addr[EBS_DATA_W-1:0];
						d.ad_oe    = bus_mux;
					end
				end
			end
			EBS_ADDR: begin
				// data phase: lines carry write data or are released for read
				d.state = EBS_STRB;
				d.strb  = cpu_strobes(q.req, strobe_style);
				d.ad_o  = q.req.wdata;
				d.ad_oe = q.req.write;
			end
			EBS_ROW: begin
				// column after row, row strobe kept low
				d.state      = EBS_COL;
				d.ma         = dram_col(q.req.addr);
				d.strb.ras_n = 1'b0;
				d.strb.rd_n  = q.req.write;
				d.strb.dw_n  = ~q.req.write;
				d.strb.cas_even_n = ~(q.req.word | ~q.req.addr[0]);
				d.strb.cas_odd_n  = ~(q.req.word | q.req.addr[0]);
				d.ad_o  = q.req.wdata;
				d.ad_oe = q.req.write;
			end
			EBS_STRB, EBS_COL: begin
				if (rdy) begin
					// cycle ends, read data taken as the strobes rise
					d.state = EBS_IDLE;
					d.done  = 1'b1;
					d.rdata = q.req.write ? q.rdata : ad_i;
					d.ad_oe = 1'b0;
					d.cs_n  = 4'hf;
				end else begin
					// wait state: every strobe holds
					d.strb = q.strb;
				end
			end
			EBS_HOLD: begin
				if (hold_req_n) begin
					d.state   = EBS_IDLE;
					d.grant_n = 1'b1;
				end else begin
					d.grant_n = 1'b0;
				end
			end
			default: begin
				d.state   = EBS_IDLE;
				d.cs_n    = 4'hf;
				d.ad_oe   = 1'b0;
				d.grant_n = 1'b1;
			end
		endcase
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q         <= '0;
			q.state   <= EBS_IDLE;
			q.strb    <= EBS_STRB_IDLE;
			q.cs_n    <= 4'hf;
			q.grant_n <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	// clock output divider
	ebs_clkout u_clkout (
		.clk    (clk),
		.rst_n  (rst_n),
		.ce     (ce),
		.sel    (clk_out_sel),
		.sub_in (sub_oscillator_input),
		.clk_o  (clock_output_pin)
	);

	// pins from the state register; req_ready is also gated by hold_req_n
	assign req_ready                = (q.state == EBS_IDLE) && hold_req_n;
	assign rsp_done                 = q.done;
	assign rsp_rdata                = q.rdata;
	assign bus_release_grant_n      = q.grant_n;
	assign addr_low                 = q.req.addr[EBS_DATA_W-1:0];
	assign addr_high                = q.req.addr[EBS_HIGH_LSB +: EBS_HIGH_W-1];
	assign inverted_top_address     = ~q.req.addr[EBS_ADDR_W-1];
	assign space_select_lines_n     = q.cs_n;
	assign dram_mux_address         = q.ma;
	assign ad_o                     = q.ad_o;
	assign ad_oe                    = q.ad_oe;
	assign rd_n                     = q.strb.rd_n;
	assign write_strobe_low_byte_n  = q.strb.wrl_n;
	assign write_strobe_high_byte_n = q.strb.wrh_n;
	assign ale                      = q.strb.ale;
	assign ras_n                    = q.strb.ras_n;
	assign column_strobe_even_n     = q.strb.cas_even_n;
	assign column_strobe_odd_n      = q.strb.cas_odd_n;
	assign dram_write_select_n      = q.strb.dw_n;
	assign bclk                     = q.bclk;

endmodule // ebs_bus

// [tb/ebs_mem.sv]
// far side model: memory and dram behind the strobes, with ready stretching
`timescale 1ns/1ps
module ebs_mem
	import ebs_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  style,
	input  wire logic [1:0]            waits,
	input  wire logic [EBS_DATA_W-1:0] addr_low,
	input  wire logic [EBS_MA_W-1:0]   ma,
	input  wire logic [EBS_DATA_W-1:0] ad_o,
	input  wire ebs_strb_t             s,
	output logic [EBS_DATA_W-1:0]      ad_i,
	output logic                       rdy
);
	logic [15:0] mem [256] = '{default: 16'h0}; // word store
	logic [1:0]  cnt_q;                          // strobe cycles seen so far
	logic [15:0] last_q;                         // last value on the data lines
	logic        dr, on, lo, hi;                 // dram cycle, strobing, lane writes
	logic [7:0]  idx;                            // word index
	assign dr = !s.ras_n;
	assign idx = dr ? ma[7:0] : addr_low[8:1];
	assign on = !(s.rd_n & s.wrl_n & s.wrh_n & s.cas_even_n & s.cas_odd_n);
	assign lo = dr ? !s.cas_even_n & !s.dw_n : style ? !s.wrl_n & !addr_low[0] : !s.wrl_n;
	assign hi = dr ? !s.cas_odd_n & !s.dw_n : style ? !s.wrl_n & !s.wrh_n : !s.wrh_n;
	assign rdy = cnt_q >= waits;
	// released lines show a changing pattern, never the old value
	assign ad_i = !s.rd_n ? mem[idx] : ~last_q;
	// count strobe cycles and store written lanes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 2'h0;
			last_q <= 16'h0;
		end else begin
			last_q <= ad_i;
			cnt_q <= on ? cnt_q + 2'(cnt_q != 2'h3) : 2'h0;
			if (lo) mem[idx][7:0] <= ad_o[7:0];
			if (hi) mem[idx][15:8] <= ad_o[15:8];
		end
	end
endmodule // ebs_mem

// [tb/ebs_bus_checker.sv]
// assertions watching the bus sequencer pins
`timescale 1ns/1ps
module ebs_bus_checker
	import ebs_pkg::*;
(
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic	ce,
	input wire logic	bus_mux,
	input wire logic	req_valid,
	input wire ebs_req_t	req,
	input wire logic	req_ready,
	input wire logic	hold_req_n,
	input wire logic	bus_release_grant_n,
	input wire logic	rdy,
	input wire logic [15:0]	addr_low,
	input wire logic [6:0]	addr_high,
	input wire logic	inverted_top_address,
	input wire logic [3:0]	space_select_lines_n,
	input wire logic [15:0]	ad_o,
	input wire logic	ad_oe,
	input wire logic	rd_n,
	input wire logic	write_strobe_low_byte_n,
	input wire logic	write_strobe_high_byte_n,
	input wire logic	ale,
	input wire logic	ras_n,
	input wire logic	column_strobe_even_n,
	input wire logic	column_strobe_odd_n,
	input wire logic	dram_write_select_n
);
	logic		tk;	// request taken at this edge
	logic [4:0]	sv;	// strobe phase pins
	assign tk = ce & req_valid & req_ready;
	assign sv = {rd_n, write_strobe_low_byte_n, write_strobe_high_byte_n,
		column_strobe_even_n, column_strobe_odd_n};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	top_addr_a: assert property (tk |=> inverted_top_address == ~$past(req.addr[23])
		&& addr_high == $past(req.addr[22:16])) else $error("high address wrong");
	space_sel_a: assert property (tk |=> space_select_lines_n == ~(4'h1 << $past(req.space)))
		else $error("chip select wrong");
	mux_addr_a: assert property (ale && bus_mux |-> ad_oe && ad_o == addr_low) else $error("no address");
	ale_pulse_a: assert property (ale |=> !ale) else $error("latch strobe too long");
	row_first_a: assert property ($fell(column_strobe_even_n) || $fell(column_strobe_odd_n)
		|-> !ras_n && $past(!ras_n)) else $error("column before row");
	dram_write_a: assert property (!dram_write_select_n |-> !ras_n && sv[1:0] != 2'h3)
		else $error("write select outside dram");
	wait_hold_a: assert property (ce && sv != 5'h1f && !rdy |=> $stable(sv)) else $error("wait ignored");
	ready_end_a: assert property (ce && sv != 5'h1f && rdy |=> sv == 5'h1f) else $error("cycle not ended");
	grant_keep_a: assert property (!hold_req_n && !bus_release_grant_n |=> !bus_release_grant_n)
		else $error("hold left early");
	grant_cause_a: assert property ($fell(bus_release_grant_n) |-> $past(!hold_req_n))
		else $error("grant without hold");
	cover property (tk && req.dram && req.write);
	cover property (sv != 5'h1f && !rdy);
	cover property (!bus_release_grant_n);
endmodule // ebs_bus_checker
bind ebs_bus ebs_bus_checker chk (.*);

// [tb/ebs_bus_test.sv]
// self-checking bench for the bus sequencer
`timescale 1ns/1ps
module ebs_bus_test
	import ebs_pkg::*;
;
	logic	clk, rst_n, ce, strobe_style, bus_mux, sub_oscillator_input, req_valid, hold_req_n, rdy;
	logic	req_ready, rsp_done, bus_release_grant_n, inverted_top_address, ad_oe, rd_n, ale, ras_n, bclk;
	logic	write_strobe_low_byte_n, write_strobe_high_byte_n, column_strobe_even_n, column_strobe_odd_n;
	logic	dram_write_select_n, clock_output_pin;
	logic [1:0]	clk_out_sel, waits;
	ebs_req_t	req;
	logic [15:0]	rsp_rdata, addr_low, ad_i, ad_o;
	logic [6:0]	addr_high;
	logic [3:0]	space_select_lines_n;
	logic [12:0]	dram_mux_address;
	int		n_mismatch = 0, checked = 0;
	logic [15:0]	exp_mem [256] = '{default: 16'h0};	// expected memory contents
	logic [16:0]	notes [$];	// {is read, expected word} per request
	logic [16:0]	nt;
	ebs_bus dut (.*);
	ebs_mem mem (.clk(clk), .rst_n(rst_n), .style(strobe_style), .waits(waits), .addr_low(addr_low),
		.ma(dram_mux_address), .ad_o(ad_o), .ad_i(ad_i), .rdy(rdy),
		.s({rd_n, write_strobe_low_byte_n, write_strobe_high_byte_n, ale, ras_n,
		column_strobe_even_n, column_strobe_odd_n, dram_write_select_n}));
	always #10 clk = ~clk;
	// count a comparison and report a mismatch
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// present one request at idle and note its expected result
	task automatic op(input ebs_req_t r);
		logic [7:0] x;
		x = r.addr[8:1];
		for (int i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge clk);
		strobe_style = 1'($urandom);
		bus_mux = 1'($urandom);
		waits = 2'($urandom_range(2));
		req = r;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		if (!r.write) notes.push_back({1'b1, exp_mem[x]});
		else begin
			if (r.word | !r.addr[0]) exp_mem[x][7:0] = r.wdata[7:0];
			if (r.word | r.addr[0]) exp_mem[x][15:8] = r.wdata[15:8];
			notes.push_back(17'h0);
		end
	endtask
	// each finished request takes the oldest note
	always @(negedge clk) begin
		if (rsp_done === 1'b1) begin
			nt = notes.size() ? notes.pop_front() : 17'h1ffff;
			if (nt[16]) chk(rsp_rdata === nt[15:0], "read data");
		end
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		close_out();
	end
	// main sequence: random traffic with holds, then clock pin rates
	initial begin
		ebs_req_t r;
		logic p;
		logic b;
		int n;
		{clk, rst_n, strobe_style, bus_mux, sub_oscillator_input, req_valid, waits, clk_out_sel} = '0;
		ce = 1'b1;
		hold_req_n = 1'b1;
		req = '0;
		void'($urandom(84888));
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		for (int k = 0; k < 300; k++) begin
			r = ebs_req_t'(($bits(ebs_req_t))'({$urandom, $urandom}));
			r.addr[8:4] = 5'h0;
			r.addr[0] = r.addr[0] & !r.word;
			op(r);
			if (k % 100 == 99) begin
				hold_req_n = 1'b0;
				repeat (8) @(negedge clk);
				chk(bus_release_grant_n === 1'b0 && req_ready === 1'b0, "hold grant");
				hold_req_n = 1'b1;
				repeat (2) @(negedge clk);
				chk(bus_release_grant_n === 1'b1, "hold release");
			end
		end
		for (int s = 0; s < 4; s++) begin
			clk_out_sel = 2'(s);
			repeat (40) @(negedge clk);
			p = clock_output_pin;
			n = 0;
			for (int i = 0; i < 64; i++) begin
				if (s == 2 && i % 4 == 0) sub_oscillator_input = !sub_oscillator_input;
				@(negedge clk);
				if (clock_output_pin !== p) n++;
				p = clock_output_pin;
			end
			chk(n == (s == 1 ? 4 : 16), "clock pin rate");
		end
		// bus clock runs at half the system clock
		p = bclk;
		n = 0;
		for (int i = 0; i < 16; i++) begin
			@(negedge clk);
			if (bclk !== p) n++;
			p = bclk;
		end
		chk(n == 16, "bus clock rate");
		// clock enable low freezes the dividers
		ce = 1'b0;
		p = clock_output_pin;
		b = bclk;
		repeat (10) @(negedge clk);
		chk(clock_output_pin === p && bclk === b, "enable freeze");
		ce = 1'b1;
		chk(notes.size() == 0, "requests left unanswered");
		close_out();
	end
endmodule // ebs_bus_test
